/* File: logic/acs_pkg.sv */
// acs_pkg: constants and types shared by the amplifier control serial slave
// assumes: system clock at 50 MHz, bus clock from the master at most 400 kHz
package acs_pkg;

    // ----------------------------------------------------------------
    // address byte layout
    // ----------------------------------------------------------------
    localparam logic [5:0] ACS_ADDR_HIGH = 6'h3E; // upper six bits 111110 of the 7-bit address
    localparam int ACS_ADDR_SEL_POS = 1; // address select bit position in the address byte
    localparam int ACS_RW_POS = 0; // read/write bit position
    localparam int ACS_BYTE_BITS = 8; // bits per byte
    localparam logic [3:0] ACS_ACK_SLOT = 4'h8; // bit index of the acknowledge clock

    // ----------------------------------------------------------------
    // data byte layout
    // ----------------------------------------------------------------
    localparam int ACS_SEL_HI = 7; // register select field, top
    localparam int ACS_SEL_LO = 6; // register select field, bottom
    localparam int ACS_EFFECT_POS = 5; // spatial effect bit and wake speed bit
    localparam int ACS_GAIN_HI = 4; // gain code top bit
    localparam int ACS_ROUTE_HI = 3; // routing code top bit
    localparam logic [1:0] ACS_SEL_MONO = 2'h0;
    localparam logic [1:0] ACS_SEL_LEFT = 2'h1;
    localparam logic [1:0] ACS_SEL_RIGHT = 2'h2;
    localparam logic [1:0] ACS_SEL_MODE = 2'h3;

    // ----------------------------------------------------------------
    // values after reset (not documented; chosen quiet)
    // ----------------------------------------------------------------
    localparam logic [4:0] ACS_GAIN_RST = 5'h00; // lowest gain
    localparam logic [3:0] ACS_ROUTE_RST = 4'h0; // every output shut down
    localparam logic [3:0] ACS_ROUTE_RSVD_MASK_UNUSED = 4'h0;

    // ----------------------------------------------------------------
    // gain tables in tenths of a dB
    // ----------------------------------------------------------------
    localparam int ACS_STEP_TENTHS = 15; // 1.5 dB per step
    localparam int ACS_MONO_MIN_TENTHS = -345; // code 00000 on mono
    localparam int ACS_STEREO_MIN_TENTHS = -405; // code 00000 on stereo

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int ACS_CLK_MHZ = 50;
    localparam int ACS_BUS_KHZ_MAX = 400; // fastest bus clock
    localparam int ACS_BUS_CYCLES_MIN = (ACS_CLK_MHZ * 1000) / ACS_BUS_KHZ_MAX;

    // ----------------------------------------------------------------
    // output routing decode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACS_PATH_OFF,
        ACS_PATH_MUTE,
        ACS_PATH_ON
    } acs_path_t;

    typedef enum logic [1:0] {
        ACS_SRC_NONE,
        ACS_SRC_MONO,
        ACS_SRC_STEREO,
        ACS_SRC_MIX
    } acs_src_t;

    typedef struct packed {
        acs_src_t src;
        acs_path_t spk;
        acs_path_t hp;
        logic valid;
    } acs_route_t;

    // decode of a routing code; reserved codes give all off and valid low
    function automatic acs_route_t acs_route_decode(input logic [3:0] code);
        acs_route_t r;
        r = '{src: ACS_SRC_NONE, spk: ACS_PATH_OFF, hp: ACS_PATH_OFF, valid: 1'b0};
        unique case (code)
            4'h0: r.valid = 1'b1;
            4'h2: r = '{src: ACS_SRC_MONO, spk: ACS_PATH_ON, hp: ACS_PATH_MUTE, valid: 1'b1};
            4'h3: r = '{src: ACS_SRC_MONO, spk: ACS_PATH_ON, hp: ACS_PATH_ON, valid: 1'b1};
            4'h4: r = '{src: ACS_SRC_MONO, spk: ACS_PATH_OFF, hp: ACS_PATH_ON, valid: 1'b1};
            4'h7: r = '{src: ACS_SRC_STEREO, spk: ACS_PATH_ON, hp: ACS_PATH_MUTE, valid: 1'b1};
            4'h8: r = '{src: ACS_SRC_STEREO, spk: ACS_PATH_ON, hp: ACS_PATH_ON, valid: 1'b1};
            4'h9: r = '{src: ACS_SRC_STEREO, spk: ACS_PATH_OFF, hp: ACS_PATH_ON, valid: 1'b1};
            4'hC: r = '{src: ACS_SRC_MIX, spk: ACS_PATH_ON, hp: ACS_PATH_MUTE, valid: 1'b1};
            4'hD: r = '{src: ACS_SRC_MIX, spk: ACS_PATH_ON, hp: ACS_PATH_ON, valid: 1'b1};
            4'hE: r = '{src: ACS_SRC_MIX, spk: ACS_PATH_OFF, hp: ACS_PATH_ON, valid: 1'b1};
            default: r.valid = 1'b0;
        endcase
        return r;
    endfunction : acs_route_decode

endpackage : acs_pkg

/* File: logic/acs_byte_if.sv */
// acs_byte_if: bytes handed from the link-side receiver to the core
// assumes: producer on the bus clock side, consumer on clk
`timescale 1ns/1ps
interface acs_byte_if;
    logic [7:0] data; // last accepted data byte, stable while toggle stands
    logic toggle; // flips once per accepted data byte
    modport rx (output data, output toggle);
    modport core (input data, input toggle);
endinterface : acs_byte_if

/* File: logic/acs_link_rx.sv */
// acs_link_rx: bit engine clocked by the serial clock of the bus
// assumes: start/stop sensed by the core and passed in as async levels
`timescale 1ns/1ps
module acs_link_rx
    import acs_pkg::*;
(
    // link clock and control
    input wire logic scl,
    input wire logic reset_n,
    input wire logic frame_rst_n, // low from a start or stop until the next scl rise
    input wire logic sda_in,
    input wire logic addr_sel,
    // open-drain drive
    output logic sda_drive_low,
    // bytes to the core
    acs_byte_if.rx bytes
);

    typedef struct packed {
        logic [3:0] bit_idx; // 0..7 data bits, 8 is the ack slot
        logic [7:0] shift;
        logic is_addr; // first byte after start
        logic matched; // address taken
        logic ignore; // unmatched; wait for next start
        logic [7:0] data;
        logic toggle;
    } acs_rx_state_t;

    acs_rx_state_t st_ff, nxt_st;
    logic ack_ff; // ack level, changed on falling scl

    // ----------------------------------------------------------------
    // sample on rising scl
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.bit_idx == ACS_ACK_SLOT) begin
            nxt_st.bit_idx = 4'h0;
            nxt_st.is_addr = 1'b0;
            if (st_ff.is_addr) begin
                nxt_st.matched = ack_ff;
                nxt_st.ignore = !ack_ff;
            end else if (st_ff.matched) begin
                nxt_st.data = st_ff.shift;
                nxt_st.toggle = !st_ff.toggle;
            end
        end else begin
            nxt_st.shift = {st_ff.shift[6:0], sda_in}; // msb first
            nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
        end
    end

    // frame reset comes from start/stop; data and toggle survive it
    always_ff @(posedge scl or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{bit_idx: 4'h0, shift: 8'h00, is_addr: 1'b1, matched: 1'b0,
                       ignore: 1'b0, data: 8'h00, toggle: 1'b0};
        end else if (!frame_rst_n) begin
            st_ff <= '{bit_idx: 4'h1, shift: {7'h00, sda_in}, is_addr: 1'b1,
                       matched: 1'b0, ignore: 1'b0, data: st_ff.data,
                       toggle: st_ff.toggle};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // ack drive on falling scl, held through the whole ack pulse
    // ----------------------------------------------------------------
    logic addr_ok;
    assign addr_ok = (st_ff.shift[7:2] == ACS_ADDR_HIGH)
                   && (st_ff.shift[ACS_ADDR_SEL_POS] == addr_sel)
                   && !st_ff.shift[ACS_RW_POS];

    always_ff @(negedge scl or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else if (st_ff.bit_idx == ACS_ACK_SLOT && !st_ff.ignore) begin
            ack_ff <= st_ff.is_addr ? addr_ok : st_ff.matched;
        end else begin
            ack_ff <= 1'b0;
        end
    end

    assign sda_drive_low = ack_ff;
    assign bytes.data = st_ff.data;
    assign bytes.toggle = st_ff.toggle;

endmodule : acs_link_rx

/* File: logic/amp_ctl_slave.sv */
// amp_ctl_slave: write-only two-wire control slave of the amplifier
// assumes: scl and sda come from pins, clk is an unrelated 50 MHz clock
`timescale 1ns/1ps
// Contract
// - address 111110 plus select pin, write
// - falling sda with scl high starts
// - address byte shifted msb first
// - sample sda on rising scl
// - ack low on match, released otherwise
// - data bytes shifted msb first
// - ack every data byte on ninth clock
// - any number of bytes applied in turn
// - rising sda with scl high stops
// - scl at most 400 kHz, sda open-drain
// - stereo gain 1.5 dB steps, 11011 is 0 dB
// - route 0 shuts down; reserved codes undefined
// - routes 2,3,4 carry mono only
// - routes 7,8,9 carry left and right
// - routes 12,13,14 mix mono, speakers double
// - left/right top bits enable spatial effects
// - wake bit 0 fast, 1 slow
// - bits 7:6 select target register
// - mono code 00000 is -34.5 dB
// - stereo code 00000 is -40.5 dB
module amp_ctl_slave
    import acs_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic reset_n,
    // two-wire bus
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // address select strap
    input wire logic addr_sel,
    // gain settings
    output logic [4:0] mono_gain,
    output logic [4:0] left_gain,
    output logic [4:0] right_gain,
    // effects and wake
    output logic speaker_spatial_en,
    output logic headphone_spatial_en,
    output logic wake_speed_sel,
    // routing
    output logic [3:0] route_code,
    output logic route_valid,
    output logic [1:0] route_src,
    output logic [1:0] speaker_path,
    output logic [1:0] headphone_path,
    output logic output_off_state
);

    // ----------------------------------------------------------------
    // start and stop detect, asynchronous to both clocks
    // ----------------------------------------------------------------
    // start/stop are sda edges during scl high; they clear the bit engine
    // until the next rising scl, which releases it with a clean frame
    logic start_flag_ff; // flips on falling sda while scl high
    logic stop_flag_ff; // flips on rising sda while scl high
    logic frame_clr_ff; // never assigned; frame_rst_n clears the bit engine instead

    always_ff @(negedge sda_i or negedge reset_n) begin
        if (!reset_n) begin
            start_flag_ff <= 1'b0;
        end else begin
            start_flag_ff <= scl ? !start_flag_ff : start_flag_ff;
        end
    end

    always_ff @(posedge sda_i or negedge reset_n) begin
        if (!reset_n) begin
            stop_flag_ff <= 1'b0;
        end else begin
            stop_flag_ff <= scl ? !stop_flag_ff : stop_flag_ff;
        end
    end

    // event toggles seen at the last rising scl
    logic [1:0] seen_ff;
    always_ff @(posedge scl or negedge reset_n) begin
        if (!reset_n) begin
            seen_ff <= 2'b00;
        end else begin
            seen_ff <= {stop_flag_ff, start_flag_ff};
        end
    end

    // frame reset: low while a start or stop is pending for the engine
    logic frame_rst_n;
    assign frame_rst_n = (seen_ff == {stop_flag_ff, start_flag_ff});

    // ----------------------------------------------------------------
    // bit engine on the link clock
    // ----------------------------------------------------------------
    acs_byte_if bytes_if ();
    logic sda_low;

    acs_link_rx u_rx (
        .scl(scl),
        .reset_n(reset_n),
        .frame_rst_n(frame_rst_n),
        .sda_in(sda_i),
        .addr_sel(addr_sel),
        .sda_drive_low(sda_low),
        .bytes(bytes_if.rx)
    );

    // ----------------------------------------------------------------
    // core state on clk
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] tog_sync; // toggle synchroniser plus edge stage
        logic [7:0] data_sync1; // data stage, stable while toggle moves
        logic [4:0] mono;
        logic [4:0] left;
        logic [4:0] right;
        logic spk_fx;
        logic hp_fx;
        logic wake;
        logic [3:0] route;
        acs_route_t dec;
        logic off; // both paths off, kept in a flop so the pin has no decode glitches
    } acs_core_t;

    acs_core_t cs_ff, nxt_cs;
    logic byte_evt; // one clk after a new byte settles

    // ----------------------------------------------------------------
    // apply received bytes
    // ----------------------------------------------------------------
    always_comb begin
        nxt_cs = cs_ff;
        nxt_cs.tog_sync = {cs_ff.tog_sync[1:0], bytes_if.toggle};
        byte_evt = cs_ff.tog_sync[2] != cs_ff.tog_sync[1];
        // data and toggle move on the same scl edge; by the time the toggle
        // has crossed two stages the data stage already holds the settled byte
        nxt_cs.data_sync1 = bytes_if.data;
        if (byte_evt) begin
            unique case (cs_ff.data_sync1[ACS_SEL_HI:ACS_SEL_LO])
                ACS_SEL_MONO: begin
                    nxt_cs.mono = cs_ff.data_sync1[ACS_GAIN_HI:0];
                end
                ACS_SEL_LEFT: begin
                    nxt_cs.left = cs_ff.data_sync1[ACS_GAIN_HI:0];
                    nxt_cs.spk_fx = cs_ff.data_sync1[ACS_EFFECT_POS];
                end
                ACS_SEL_RIGHT: begin
                    nxt_cs.right = cs_ff.data_sync1[ACS_GAIN_HI:0];
                    nxt_cs.hp_fx = cs_ff.data_sync1[ACS_EFFECT_POS];
                end
                ACS_SEL_MODE: begin
                    nxt_cs.wake = cs_ff.data_sync1[ACS_EFFECT_POS];
                    nxt_cs.route = cs_ff.data_sync1[ACS_ROUTE_HI:0];
                end
            endcase
        end
        nxt_cs.dec = acs_route_decode(nxt_cs.route);
        // both paths off: whole amplifier in shutdown (route 0 or reserved)
        nxt_cs.off = (nxt_cs.dec.spk == ACS_PATH_OFF)
                     && (nxt_cs.dec.hp == ACS_PATH_OFF);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_ff <= '{tog_sync: 3'h0, data_sync1: 8'h00, mono: ACS_GAIN_RST,
                       left: ACS_GAIN_RST, right: ACS_GAIN_RST, spk_fx: 1'b0,
                       hp_fx: 1'b0, wake: 1'b0, route: ACS_ROUTE_RST,
                       dec: '{src: ACS_SRC_NONE, spk: ACS_PATH_OFF,
                              hp: ACS_PATH_OFF, valid: 1'b1}, off: 1'b1};
        end else begin
            cs_ff <= nxt_cs;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // sda pad: open drain, driven only low during an ack
    assign sda_o = 1'b0;
    assign sda_oe = sda_low;
    assign mono_gain = cs_ff.mono;
    assign left_gain = cs_ff.left;
    assign right_gain = cs_ff.right;
    assign speaker_spatial_en = cs_ff.spk_fx;
    assign headphone_spatial_en = cs_ff.hp_fx;
    assign wake_speed_sel = cs_ff.wake;
    assign route_code = cs_ff.route;
    assign route_valid = cs_ff.dec.valid;
    assign route_src = cs_ff.dec.src;
    assign speaker_path = cs_ff.dec.spk;
    assign headphone_path = cs_ff.dec.hp;
    // shutdown flag straight from its flop
    assign output_off_state = cs_ff.off;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_route_zero_off;
        @(posedge clk) disable iff (!reset_n)
        (route_code == 4'h0) |-> output_off_state;
    endproperty
    a_route_zero_off: assert property (p_route_zero_off)
        else $error("route 0 not shut down");

    property p_mono_routes;
        @(posedge clk) disable iff (!reset_n)
        (route_code inside {4'h2, 4'h3, 4'h4}) |-> (route_src == ACS_SRC_MONO);
    endproperty
    a_mono_routes: assert property (p_mono_routes)
        else $error("mono route has wrong source");

    property p_stereo_routes;
        @(posedge clk) disable iff (!reset_n)
        (route_code inside {4'h7, 4'h8, 4'h9}) |-> (route_src == ACS_SRC_STEREO);
    endproperty
    a_stereo_routes: assert property (p_stereo_routes)
        else $error("stereo route has wrong source");

    property p_mix_routes;
        @(posedge clk) disable iff (!reset_n)
        (route_code == 4'hE) |-> (speaker_path == ACS_PATH_OFF
                                  && headphone_path == ACS_PATH_ON
                                  && route_src == ACS_SRC_MIX);
    endproperty
    a_mix_routes: assert property (p_mix_routes)
        else $error("mix route 14 decoded wrong");

    property p_reserved;
        @(posedge clk) disable iff (!reset_n)
        (route_code inside {4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hF}) |-> !route_valid;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved route reported valid");

    property p_update_only_on_byte;
        @(posedge clk) disable iff (!reset_n)
        !byte_evt |=> $stable(mono_gain) && $stable(route_code) && $stable(left_gain);
    endproperty
    a_update_only_on_byte: assert property (p_update_only_on_byte)
        else $error("setting changed without a byte");

    property p_mode_write;
        @(posedge clk) disable iff (!reset_n)
        (byte_evt && cs_ff.data_sync1[7:6] == ACS_SEL_MODE)
            |=> (route_code == $past(cs_ff.data_sync1[3:0])
                 && wake_speed_sel == $past(cs_ff.data_sync1[5]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode byte not applied");

    property p_left_write;
        @(posedge clk) disable iff (!reset_n)
        (byte_evt && cs_ff.data_sync1[7:6] == ACS_SEL_LEFT)
            |=> (speaker_spatial_en == $past(cs_ff.data_sync1[5])
                 && left_gain == $past(cs_ff.data_sync1[4:0]));
    endproperty
    a_left_write: assert property (p_left_write)
        else $error("left byte not applied");

    // ack edges must fall while scl is low, else the slave fakes a start or stop
    property p_ack_only_low;
        @(posedge clk) disable iff (!reset_n)
        (sda_oe || $changed(sda_oe)) |-> (sda_o == 1'b0) && (!$changed(sda_oe) || !scl);
    endproperty
    a_ack_only_low: assert property (p_ack_only_low)
        else $error("sda driven high");

endmodule : amp_ctl_slave

/* File: testbench/acs_host_model.sv */
// acs_host_model: behavioural two-wire master that writes control bytes
// assumes: sda is resolved outside with a pull-up, scl half period 32 ns
`timescale 1ns/1ps
module acs_host_model (
    // bus lines
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    realtime lag = 0.0; // extra scl low time, lets the master run slowly

    // ----------------------------------------------------------------
    // bus idles high, sda only ever released, never driven high
    // ----------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // start, also usable as a repeated start with scl low
    task automatic start_cond();
        #3.7;
        sda_rel = 1'b1;
        #(16.0 + lag);
        scl = 1'b1;
        #16.0;
        sda_rel = 1'b0;
        #16.0;
        scl = 1'b0;
        #16.0;
    endtask : start_cond

    // n bits msb first; a whole byte gets the ack clock as well
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            sda_rel = b[i];
            #(16.0 + lag);
            scl = 1'b1; // data held for the whole high time
            #32.0;
            scl = 1'b0;
            #16.0;
        end
        if (n == 8) begin
            sda_rel = 1'b1;
            #(16.0 + lag);
            scl = 1'b1;
            #1.0;
            ack = ~sda;
            #30.0;
            ack = ack & ~sda; // low at 1 ns and again at 31 ns into the high pulse
            #1.0;
            scl = 1'b0;
            #16.0;
        end
    endtask : send

    // stop, then the bus is left idle high
    task automatic stop_cond();
        sda_rel = 1'b0;
        #(16.0 + lag);
        scl = 1'b1;
        #16.0;
        sda_rel = 1'b1;
        #32.0;
    endtask : stop_cond
endmodule : acs_host_model

/* File: testbench/amp_ctl_slave_test.sv */
// amp_ctl_slave_test: writes settings over the bus and checks the outputs
// assumes: acs_host_model as the master, pull-up on sda
`timescale 1ns/1ps
module amp_ctl_slave_test;
    import acs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic addr_sel = 1'b0;
    logic host_scl, host_rel, sda, sda_o, sda_oe, ack;
    logic [4:0] mono_gain, left_gain, right_gain, e_mono, e_left, e_right;
    logic speaker_spatial_en, headphone_spatial_en, wake_speed_sel, e_spk, e_hp, e_wake;
    logic [3:0] route_code, e_route;
    logic route_valid, output_off_state;
    logic [1:0] route_src, speaker_path, headphone_path;
    logic [7:0] b;
    int bad_count = 0;
    int checks = 0;

    // ----------------------------------------------------------------
    // clock, wire and instances
    // ----------------------------------------------------------------
    always #10 clk = ~clk;
    assign sda = host_rel & ~(sda_oe & ~sda_o); // open drain with pull-up
    acs_host_model host (.scl(host_scl), .sda_rel(host_rel), .sda(sda));
    amp_ctl_slave uut (.clk(clk), .reset_n(reset_n), .scl(host_scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel), .mono_gain(mono_gain),
        .left_gain(left_gain), .right_gain(right_gain),
        .speaker_spatial_en(speaker_spatial_en), .headphone_spatial_en(headphone_spatial_en),
        .wake_speed_sel(wake_speed_sel), .route_code(route_code), .route_valid(route_valid),
        .route_src(route_src), .speaker_path(speaker_path), .headphone_path(headphone_path),
        .output_off_state(output_off_state));

    // ----------------------------------------------------------------
    // compare, verdict, expectations
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // target register picked by the top two bits
    task automatic apply(input logic [7:0] d);
        case (d[7:6])
            ACS_SEL_MONO: e_mono = d[4:0];
            ACS_SEL_LEFT: {e_spk, e_left} = d[5:0];
            ACS_SEL_RIGHT: {e_hp, e_right} = d[5:0];
            default: {e_wake, e_route} = {d[5], d[3:0]};
        endcase
    endtask : apply

    // routing table: {valid, source, speaker, headphone}
    function automatic logic [6:0] rexp(input logic [3:0] c);
        logic [1:0] s;
        logic [1:0] p;
        logic [1:0] h;
        s = (c inside {2, 3, 4}) ? ACS_SRC_MONO : (c inside {7, 8, 9}) ? ACS_SRC_STEREO
            : (c inside {12, 13, 14}) ? ACS_SRC_MIX : ACS_SRC_NONE;
        p = (c inside {2, 3, 7, 8, 12, 13}) ? ACS_PATH_ON : ACS_PATH_OFF;
        h = (c inside {2, 7, 12}) ? ACS_PATH_MUTE
            : (c inside {3, 4, 8, 9, 13, 14}) ? ACS_PATH_ON : ACS_PATH_OFF;
        return {~(c inside {1, 5, 6, 10, 11, 15}), s, p, h};
    endfunction : rexp

    // settings land a few clk after the ack, so wait before looking
    task automatic chk_all();
        logic [6:0] r;
        r = rexp(e_route);
        repeat (6) @(posedge clk);
        chk("mono_gain", 8'(e_mono), 8'(mono_gain));
        chk("left_gain", 8'(e_left), 8'(left_gain));
        chk("right_gain", 8'(e_right), 8'(right_gain));
        chk("effects", 8'({e_spk, e_hp, e_wake}),
            8'({speaker_spatial_en, headphone_spatial_en, wake_speed_sel}));
        chk("route_code", 8'(e_route), 8'(route_code));
        chk("route_decode", 8'(r), 8'({route_valid, route_src, speaker_path,
            headphone_path}));
        chk("output_off_state", 8'(r[3:0] == 4'h0), 8'(output_off_state));
    endtask : chk_all

    // whole write; the rest is dropped when the address gets no ack
    task automatic xfer(input logic [7:0] adr, input logic [7:0] d [4], input int n,
            input logic hit);
        host.start_cond();
        host.send(adr, 8, ack);
        chk("address_ack", 8'(hit), 8'(ack));
        for (int k = 0; k < n && ack === 1'b1; k++) begin
            host.send(d[k], 8, ack);
            chk("data_ack", 8'h01, 8'(ack));
            apply(d[k]);
        end
        host.stop_cond();
        chk_all();
    endtask : xfer

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {e_mono, e_left, e_right, e_spk, e_hp, e_wake, e_route} = '0;
        repeat (12) @(posedge clk);
        #2 reset_n = 1'b1;
        chk_all(); // quiet values after reset
        // mono, left with effect on and then 6 dB lower, mode, in one frame
        xfer(8'hF8, '{8'h1F, 8'h7B, 8'h77, 8'hED}, 4, 1'b1);
        // every routing code, wake bit alternating
        host.start_cond();
        host.send(8'hF8, 8, ack);
        chk("address_ack", 8'h01, 8'(ack));
        for (int i = 0; i < 16; i++) begin
            b = {2'b11, i[0], 1'b0, i[3:0]};
            host.send(b, 8, ack);
            chk("data_ack", 8'h01, 8'(ack));
            apply(b);
            chk_all();
        end
        host.stop_cond();
        // foreign address and a read are both refused
        xfer(8'hFA, '{8'h05, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
        xfer(8'hF9, '{8'h05, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
        @(posedge clk);
        #2 addr_sel = 1'b1;
        xfer(8'hF8, '{8'h05, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
        xfer(8'hFA, '{8'h05, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
        // master keeps talking after a refused address
        host.start_cond();
        host.send(8'hF8, 8, ack);
        host.send(8'h1F, 8, ack);
        chk("ignored_ack", 8'h00, 8'(ack));
        host.stop_cond();
        chk_all();
        // half a byte, repeated start, then a good byte
        host.start_cond();
        host.send(8'hFA, 8, ack);
        host.send(8'h3F, 4, ack);
        host.start_cond();
        host.send(8'hFA, 8, ack);
        host.send(8'h4A, 8, ack);
        chk("data_ack", 8'h01, 8'(ack));
        host.stop_cond();
        apply(8'h4A);
        chk_all();
        // slow master
        host.lag = 400.0;
        xfer(8'hFA, '{8'hAB, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
        host.lag = 0.0;
        // reset in mid-run, then a write must still land
        @(posedge clk);
        #2 reset_n = 1'b0;
        repeat (3) @(posedge clk);
        #2 reset_n = 1'b1;
        {e_mono, e_left, e_right, e_spk, e_hp, e_wake, e_route} = '0;
        chk_all();
        xfer(8'hFA, '{8'h1B, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
        report_and_stop();
    end

    // hang guard, well beyond the expected 34 us of traffic
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule : amp_ctl_slave_test
